// *** core/mcr_consts.svh ***
// Operation
// - Leak counter loads the full 15-bit value only on strobe rising edge.
// - Load strobe bit reads one after device reset.
// - Counter reset bit clears performance counters, then self clears to zero.
// - Mapper reset bit holds the mapper in reset until written zero.
// - Desynchronizer reset bit recentres both desynchronizer FIFOs.
// - Parity bit selects data-only coverage or all bus signals coverage.
// - External and drop timing: split bit routes frame pulse to separate pin.
// - Add bus timing always takes frame pulse from the separate pin.
// - Stuffing AIS select uses internal bit stuffing instead of AIS clock.
// - Stuffing AIS select is zero after power-up.
// - Stuffed AIS while auto receive AIS and drop bus clock present disables monitor and AIS detection.
// - Lost drop bus clock stops stuffed receive AIS generation.
// - Leak value one decrements the counter every three rows, scaling upward.
// - Counter zero flag follows counter equal zero, cleared by a preset.
`ifndef MCR_CONSTS_SVH
`define MCR_CONSTS_SVH
`define MCR_ADDR_LEAK_LO     8'h1A
`define MCR_ADDR_LEAK_HI     8'h1B
`define MCR_ADDR_GCTL        8'h1C
`define MCR_LEAK_LO_RST      8'h01
`define MCR_LEAK_HI_RST      8'h01
`define MCR_GCTL_RST         8'h00
`define MCR_BIT_LOAD         0
`define MCR_BIT_CNT_CLR      7
`define MCR_BIT_MAP_RST      6
`define MCR_BIT_DESYNC_RST   5
`define MCR_BIT_PARITY       2
`define MCR_BIT_SPLIT        1
`define MCR_BIT_STUFF        0
`define MCR_CLR_CYCLES       4'h4
`define MCR_ROWS_PER_STEP    2'h3
`endif

// *** core/mcr_pkg.sv ***
package mcr_pkg;
	typedef enum logic [1:0] {
		MCR_TM_DROP = 2'h0,
		MCR_TM_ADD  = 2'h1,
		MCR_TM_EXT  = 2'h2
	} mcr_timing_t;
	typedef struct packed {
		logic       cs;
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mcr_bus_t;
	typedef struct packed {
		logic parity_payload_only;
		logic add_frame_pulse_pin;
		logic add_combined_frame_marker;
		logic stuffed_ais_tx;
		logic stuffed_ais_rx;
		logic rx_monitor_disable;
	} mcr_ctl_t;
endpackage : mcr_pkg

// *** core/mcr_leak_counter.sv ***
`timescale 1ns/100ps
`include "mcr_consts.svh"
module mcr_leak_counter #(
	parameter int WIDTH = 15
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             preset,
	input  wire logic [WIDTH-1:0] preset_value,
	input  wire logic             row_tick,
	input  wire logic [WIDTH-1:0] rate,
	output logic                  zero_flag
);
	logic [WIDTH-1:0] cnt_q, cnt_d;
	logic [WIDTH-1:0] pace_q, pace_d;
	logic [1:0]       row_q, row_d;
	logic             zero_q, zero_d;

	// ==========================================
	// Decrement pacing
	always_comb begin
		cnt_d  = cnt_q;
		pace_d = pace_q;
		row_d  = row_q;
		if (preset) begin
			cnt_d  = preset_value;
			pace_d = '0;
			row_d  = '0;
		end else if (row_tick) begin
			if (row_q == `MCR_ROWS_PER_STEP - 2'h1) begin
				row_d = '0;
				if (pace_q + WIDTH'(1) >= rate) begin
					pace_d = '0;
					if (cnt_q != '0)
						cnt_d = cnt_q - WIDTH'(1);
				end else begin
					pace_d = pace_q + WIDTH'(1);
				end
			end else begin
				row_d = row_q + 2'h1;
			end
		end
		zero_d = preset ? 1'b0 : (cnt_d == '0);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			pace_q <= '0;
			row_q  <= '0;
			zero_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			pace_q <= pace_d;
			row_q  <= row_d;
			zero_q <= zero_d;
		end
	end

	assign zero_flag = zero_q;
endmodule : mcr_leak_counter

// *** core/mcr_regs.sv ***
`timescale 1ns/100ps
`include "mcr_consts.svh"
module mcr_regs (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  mcr_pkg::mcr_bus_t     bus,
	output logic [7:0]            rdata,
	input  wire mcr_pkg::mcr_timing_t timing_mode,
	input  wire logic             frame_pulse_in,
	input  wire logic             path_start_in,
	input  wire logic             add_frame_pulse_in,
	input  wire logic             rx_ais_auto,
	input  wire logic             drop_clock_lost,
	input  wire logic             row_tick,
	output mcr_pkg::mcr_ctl_t     ctl,
	output logic                  perf_counter_clear,
	output logic                  mapper_reset_hold,
	output logic                  desync_recentre,
	output logic                  rx_frame_pulse,
	output logic                  leak_counter_zero_flag
);
	logic [7:0] leak_lo_q, leak_lo_d;
	logic [7:0] leak_hi_q, leak_hi_d;
	logic [7:0] gctl_q, gctl_d;
	logic [3:0] clr_cnt_q, clr_cnt_d;
	logic       desync_q, desync_d;
	logic       preset_q, preset_d;
	logic [7:0] rdata_q, rdata_d;
	mcr_pkg::mcr_ctl_t ctl_q, ctl_d;
	logic       rxfp_q, rxfp_d;
	logic       wr_lo, wr_hi, wr_gc;

	assign wr_lo = bus.cs && bus.wr && (bus.addr == `MCR_ADDR_LEAK_LO);
	assign wr_hi = bus.cs && bus.wr && (bus.addr == `MCR_ADDR_LEAK_HI);
	assign wr_gc = bus.cs && bus.wr && (bus.addr == `MCR_ADDR_GCTL);

	// ==========================================
	// Register writes
	always_comb begin
		leak_lo_d = leak_lo_q;
		leak_hi_d = leak_hi_q;
		gctl_d    = gctl_q;
		clr_cnt_d = clr_cnt_q;
		desync_d  = 1'b0;
		preset_d  = 1'b0;
		if (wr_lo)
			leak_lo_d = bus.wdata;
		if (wr_hi) begin
			leak_hi_d = bus.wdata;
			preset_d  = bus.wdata[`MCR_BIT_LOAD] && !leak_hi_q[`MCR_BIT_LOAD];
		end
		if (clr_cnt_q != 4'h0) begin
			clr_cnt_d = clr_cnt_q - 4'h1;
			if (clr_cnt_q == 4'h1)
				gctl_d[`MCR_BIT_CNT_CLR] = 1'b0;
		end
		if (wr_gc) begin
			gctl_d = bus.wdata;
			gctl_d[`MCR_BIT_DESYNC_RST] = 1'b0;
			desync_d = bus.wdata[`MCR_BIT_DESYNC_RST];
			if (bus.wdata[`MCR_BIT_CNT_CLR])
				clr_cnt_d = `MCR_CLR_CYCLES;
		end
	end

	// ==========================================
	// Control outputs
	always_comb begin
		ctl_d.parity_payload_only = gctl_q[`MCR_BIT_PARITY];
		if (timing_mode == mcr_pkg::MCR_TM_ADD) begin
			ctl_d.add_frame_pulse_pin       = 1'b0;
			ctl_d.add_combined_frame_marker = 1'b0;
			rxfp_d = add_frame_pulse_in;
		end else begin
			rxfp_d = frame_pulse_in;
			if (gctl_q[`MCR_BIT_SPLIT]) begin
				ctl_d.add_frame_pulse_pin       = frame_pulse_in;
				ctl_d.add_combined_frame_marker = path_start_in;
			end else begin
				ctl_d.add_frame_pulse_pin       = 1'b0;
				ctl_d.add_combined_frame_marker = frame_pulse_in | path_start_in;
			end
		end
		ctl_d.stuffed_ais_tx = gctl_q[`MCR_BIT_STUFF];
		ctl_d.stuffed_ais_rx = gctl_q[`MCR_BIT_STUFF] && !drop_clock_lost;
		ctl_d.rx_monitor_disable = gctl_q[`MCR_BIT_STUFF] && rx_ais_auto
			&& !drop_clock_lost;
		unique case (bus.addr)
			`MCR_ADDR_LEAK_LO: rdata_d = leak_lo_q;
			`MCR_ADDR_LEAK_HI: rdata_d = leak_hi_q;
			`MCR_ADDR_GCTL:    rdata_d = gctl_q;
			default:           rdata_d = 8'h00;
		endcase
		if (!(bus.cs && bus.rd))
			rdata_d = 8'h00;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			leak_lo_q <= `MCR_LEAK_LO_RST;
			leak_hi_q <= `MCR_LEAK_HI_RST;
			gctl_q    <= `MCR_GCTL_RST;
			clr_cnt_q <= 4'h0;
			desync_q  <= 1'b0;
			preset_q  <= 1'b0;
			rdata_q   <= 8'h00;
			ctl_q     <= '0;
			rxfp_q    <= 1'b0;
		end else begin
			leak_lo_q <= leak_lo_d;
			leak_hi_q <= leak_hi_d;
			gctl_q    <= gctl_d;
			clr_cnt_q <= clr_cnt_d;
			desync_q  <= desync_d;
			preset_q  <= preset_d;
			rdata_q   <= rdata_d;
			ctl_q     <= ctl_d;
			rxfp_q    <= rxfp_d;
		end
	end

	// ==========================================
	// Leak counter
	mcr_leak_counter #(
		.WIDTH(15)
	) u_leak (
		.clock        (clock),
		.rst_n        (rst_n),
		.preset       (preset_q),
		.preset_value ({leak_hi_q[7:1], leak_lo_q}),
		.row_tick     (row_tick),
		.rate         ({leak_hi_q[7:1], leak_lo_q}),
		.zero_flag    (leak_counter_zero_flag)
	);

	assign rdata              = rdata_q;
	assign ctl                = ctl_q;
	assign perf_counter_clear = gctl_q[`MCR_BIT_CNT_CLR];
	assign mapper_reset_hold  = gctl_q[`MCR_BIT_MAP_RST];
	assign desync_recentre    = desync_q;
	assign rx_frame_pulse     = rxfp_q;
endmodule : mcr_regs

// *** sim/mcr_regs_props.sv ***
`timescale 1ns/100ps
// ====================
// Register bank checker
module mcr_regs_props (
	input wire logic		clock,
	input wire logic		rst_n,
	input mcr_pkg::mcr_bus_t	bus,
	input wire mcr_pkg::mcr_timing_t	timing_mode,
	input wire logic		rx_ais_auto,
	input wire logic		drop_clock_lost,
	input mcr_pkg::mcr_ctl_t	ctl,
	input wire logic		perf_counter_clear,
	input wire logic		mapper_reset_hold,
	input wire logic		desync_recentre
);
	wire logic gw = bus.cs && bus.wr && bus.addr == 8'h1C;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	property p_clr; $rose(perf_counter_clear) |-> perf_counter_clear[*4] ##1 !perf_counter_clear; endproperty
	a_clr: assert property (p_clr) else $error("clear length");
	property p_hold; !gw |=> $stable(mapper_reset_hold); endproperty
	a_hold: assert property (p_hold) else $error("hold moved");
	property p_des; 1'b1 |=> desync_recentre == $past(gw && bus.wdata[5]); endproperty
	a_des: assert property (p_des) else $error("recentre");
	property p_par; gw |=> ##1 ctl.parity_payload_only == $past(bus.wdata[2], 2); endproperty
	a_par: assert property (p_par) else $error("parity");
	property p_add; timing_mode == mcr_pkg::MCR_TM_ADD |=> !ctl.add_frame_pulse_pin; endproperty
	a_add: assert property (p_add) else $error("add pin");
	property p_tx; gw |=> ##1 ctl.stuffed_ais_tx == $past(bus.wdata[0], 2); endproperty
	a_tx: assert property (p_tx) else $error("stuff tx");
	property p_lost; drop_clock_lost |=> !ctl.stuffed_ais_rx; endproperty
	a_lost: assert property (p_lost) else $error("stuff rx");
	property p_mon; ctl.rx_monitor_disable |-> ctl.stuffed_ais_tx; endproperty
	a_mon: assert property (p_mon) else $error("monitor");
	property p_mon_on; ctl.stuffed_ais_tx && $past(rx_ais_auto) && !$past(drop_clock_lost)
		|-> ctl.rx_monitor_disable; endproperty
	a_mon_on: assert property (p_mon_on) else $error("monitor on");
	c_clr: cover property ($rose(perf_counter_clear));
	c_des: cover property (desync_recentre);
	c_mon: cover property (ctl.rx_monitor_disable);
endmodule : mcr_regs_props
bind mcr_regs mcr_regs_props u_props (.clock, .rst_n, .bus, .timing_mode, .rx_ais_auto,
	.drop_clock_lost,
	.ctl, .perf_counter_clear, .mapper_reset_hold, .desync_recentre);

// *** sim/mcr_cpu_model.sv ***
`timescale 1ns/100ps
// ====================
// Processor model
module mcr_cpu_model (
	input wire logic		clock,
	input wire logic [7:0]	rdata,
	output mcr_pkg::mcr_bus_t	bus
);
	initial bus = '{1'b0, 1'b0, 1'b0, 8'hFF, 8'hFF};
	task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		bus = '{1'b1, w, !w, a, d};
		@(posedge clock);
		#1;
		q = rdata;
		bus = '{1'b0, 1'b0, 1'b0, ~a, ~d};
		@(posedge clock);
		#1;
	endtask : acc
endmodule : mcr_cpu_model

// *** sim/testbench.sv ***
`timescale 1ns/100ps
// ====================
// Register bank bench
module testbench;
	logic			clock = 1'b0, rst_n = 1'b0, path_start_in = 1'b0;
	logic			frame_pulse_in = 1'b0, add_frame_pulse_in = 1'b0, row_tick = 1'b0;
	logic			rx_ais_auto = 1'b0, drop_clock_lost = 1'b0, leak_counter_zero_flag;
	logic			perf_counter_clear, mapper_reset_hold, desync_recentre, rx_frame_pulse;
	logic [7:0]		rdata, q;
	logic [7:0]		n_recentre = 8'h00;
	mcr_pkg::mcr_timing_t	timing_mode = mcr_pkg::MCR_TM_DROP;
	mcr_pkg::mcr_bus_t	bus;
	mcr_pkg::mcr_ctl_t	ctl;
	int			err_total = 0, n_compared = 0, cyc = 0;
	mcr_cpu_model cpu_u (.clock, .rdata, .bus);
	mcr_regs dut_u (.clock, .rst_n, .bus, .rdata, .timing_mode, .frame_pulse_in, .path_start_in,
		.add_frame_pulse_in, .rx_ais_auto, .drop_clock_lost, .row_tick, .ctl,
		.perf_counter_clear, .mapper_reset_hold, .desync_recentre, .rx_frame_pulse,
		.leak_counter_zero_flag);
	initial forever #10 clock = ~clock;
	always @(posedge clock)
		if (desync_recentre)
			n_recentre <= n_recentre + 8'h01;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic chk(input logic [7:0] s, e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		cpu_u.acc(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		cpu_u.acc(1'b0, a, 8'h00, q);
		chk(q, e);
	endtask : rd
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask : step
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		step(20);
		rst_n = 1'b1;
		rd(8'h1A, 8'h01);
		rd(8'h1B, 8'h01);
		rd(8'h1C, 8'h00);
		rd(8'h30, 8'h00);
		wr(8'h1B, 8'h00);
		wr(8'h1A, 8'h00);
		wr(8'h1B, 8'h01);
		chk(leak_counter_zero_flag, 8'h00);
		step(1);
		chk(leak_counter_zero_flag, 8'h01);
		wr(8'h1A, 8'h01);
		wr(8'h1B, 8'h01);
		chk(leak_counter_zero_flag, 8'h01);
		wr(8'h1B, 8'h00);
		wr(8'h1B, 8'h01);
		chk(leak_counter_zero_flag, 8'h00);
		repeat (3) begin
			chk(leak_counter_zero_flag, 8'h00);
			row_tick = 1'b1;
			step(1);
			row_tick = 1'b0;
			step(1);
		end
		step(2);
		chk(leak_counter_zero_flag, 8'h01);
		wr(8'h1C, 8'h80);
		chk(perf_counter_clear, 8'h01);
		step(6);
		rd(8'h1C, 8'h00);
		wr(8'h1C, 8'h64);
		rd(8'h1C, 8'h44);
		chk(mapper_reset_hold, 8'h01);
		chk(ctl.parity_payload_only, 8'h01);
		chk(n_recentre, 8'h01);
		wr(8'h1C, 8'h02);
		for (int m = 0; m < 3; m++) begin
			timing_mode = mcr_pkg::mcr_timing_t'(m);
			frame_pulse_in = 1'b1;
			add_frame_pulse_in = 1'b1;
			step(1);
			frame_pulse_in = 1'b0;
			add_frame_pulse_in = 1'b0;
			chk(ctl.add_frame_pulse_pin, {7'h00, m != 1});
			chk(rx_frame_pulse, 8'h01);
			step(1);
		end
		path_start_in = 1'b1;
		step(1);
		path_start_in = 1'b0;
		chk(ctl.add_combined_frame_marker, 8'h01);
		chk(ctl.add_frame_pulse_pin, 8'h00);
		wr(8'h1C, 8'h00);
		frame_pulse_in = 1'b1;
		step(1);
		frame_pulse_in = 1'b0;
		chk(ctl.add_combined_frame_marker, 8'h01);
		rx_ais_auto = 1'b1;
		wr(8'h1C, 8'h01);
		chk(ctl.stuffed_ais_tx, 8'h01);
		chk(ctl.rx_monitor_disable, 8'h01);
		chk(ctl.stuffed_ais_rx, 8'h01);
		drop_clock_lost = 1'b1;
		step(2);
		chk(ctl.stuffed_ais_rx, 8'h00);
		wr(8'h1B, 8'hFE);
		rd(8'h1B, 8'hFE);
		rst_n = 1'b0;
		step(2);
		rst_n = 1'b1;
		rd(8'h1B, 8'h01);
		rd(8'h1C, 8'h00);
		complete_run();
	end
endmodule : testbench
